/* File: design/tws_pkg.sv */
// constants shared by both ends of the two-wire slave receiver link
package tws_pkg;
    // ***********************************
    // timing
    // ***********************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCL_QTR_NS = 625;
    localparam int SCL_QTR_CYC = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ***********************************
    // device register indices
    // ***********************************
    localparam logic [1:0] REG_OWN_ADDR = 2'h0;
    localparam logic [1:0] REG_CTRL = 2'h1;
    localparam logic [1:0] REG_STATUS = 2'h2;
    localparam logic [1:0] REG_DATA = 2'h3;

    // bus_control bit positions
    localparam int CTRL_IRQ_FLAG = 7;
    localparam int CTRL_ACK_EN = 6;
    localparam int CTRL_START_REQ = 5;
    localparam int CTRL_STOP_REQ = 4;
    localparam int CTRL_WCOL = 3;
    localparam int CTRL_IFACE_EN = 2;
    localparam int CTRL_IRQ_EN = 0;

    // reset values
    localparam logic [7:0] OWN_ADDR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'hff;

    // ***********************************
    // status codes and addresses
    // ***********************************
    localparam logic [7:0] ST_NO_INFO = 8'hf8;
    localparam logic [7:0] ST_SLA_W = 8'h60;
    localparam logic [7:0] ST_ARB_SLA_W = 8'h68;
    localparam logic [7:0] ST_GCA = 8'h70;
    localparam logic [7:0] ST_ARB_GCA = 8'h78;
    localparam logic [7:0] ST_DATA_ACK = 8'h80;
    localparam logic [7:0] ST_DATA_NACK = 8'h88;
    localparam logic [7:0] ST_GC_DATA_ACK = 8'h90;
    localparam logic [7:0] ST_GC_DATA_NACK = 8'h98;
    localparam logic [7:0] ST_STOP_RESTART = 8'ha0;
    localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;

    // ***********************************
    // master end apb registers
    // ***********************************
    localparam logic [11:0] HOST_CMD_OFS = 12'h000;
    localparam logic [11:0] HOST_STATUS_OFS = 12'h004;
    localparam int CMD_START_BIT = 8;
    localparam int CMD_STOP_BIT = 9;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NACK_BIT = 1;
endpackage

/* File: design/tws_if.sv */
// two-wire link between the master end and the slave receiver end
`timescale 1ns/1ps
interface tws_if;
    logic dev_scl_o;
    logic dev_scl_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic mst_scl_o;
    logic mst_scl_oe;
    logic mst_sda_o;
    logic mst_sda_oe;
    logic scl_line;
    logic sda_line;

    // open-drain wired-and with pull-up
    assign scl_line = !((dev_scl_oe && !dev_scl_o) || (mst_scl_oe && !mst_scl_o));
    assign sda_line = !((dev_sda_oe && !dev_sda_o) || (mst_sda_oe && !mst_sda_o));

    modport device (
        input scl_line,
        input sda_line,
        output dev_scl_o,
        output dev_scl_oe,
        output dev_sda_o,
        output dev_sda_oe
    );

    modport master (
        input scl_line,
        input sda_line,
        output mst_scl_o,
        output mst_scl_oe,
        output mst_sda_o,
        output mst_sda_oe
    );
endinterface

/* File: design/tws_slave_rx.sv */
// slave receiver end of the two-wire serial interface
//
// Overview of operation
// RQ1: upper seven bits own address; lsb enables call
// RQ2: software sets interface enable before reception
// RQ3: software sets ack enable, clears start/stop
// RQ4: address plus direction zero selects receive
// RQ5: own write address sets flag, status valid
// RQ6: own address write acked reports 60
// RQ7: arbitration lost then own address reports 68
// RQ8: general call acked reports 70
// RQ9: arbitration lost then general call reports 78
// RQ10: own-address data acked reports 80, data readable
// RQ11: flag clear continues; ack per ack enable
// RQ12: own-address data not acked reports 88
// RQ13: after 88, not addressed; ack enable gates recognition
// RQ14: ack enable cleared gives nack next byte
// RQ15: ack enable zero ignores address, keeps monitoring
// RQ16: sleep still acks address and wakes part
// RQ17: scl held low until flag cleared after wake
// RQ18: data register need not hold byte after sleep
// RQ19: software masks prescaler bits before reading status
// RQ20: general call data acked reports 90
// RQ21: stop or restart while addressed reports a0
// RQ22: general call data nacked returns not addressed
// RQ23: scl stretched low while flag set; here only in S_HOLD, so a flag set with a0 does not stretch
`timescale 1ns/1ps
module tws_slave_rx (
    // system
    input wire logic clk,
    input wire logic nrst,
    // two-wire link
    tws_if.device link,
    // cpu register port
    input wire logic [1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // power and arbitration
    input wire logic sleep_mode,
    input wire logic arb_lost,
    output logic wake_req
);
    import tws_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK, S_HOLD, S_DATA, S_SKIP} tws_state_t;

    // ***********************************
    // pin synchronisers
    // ***********************************
    logic [2:0] scl_sync_ff;
    logic [2:0] sda_sync_ff;
    logic scl_ff;
    logic sda_ff;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_sync_ff <= 3'h7;
            sda_sync_ff <= 3'h7;
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[1:0], link.scl_line};
            sda_sync_ff <= {sda_sync_ff[1:0], link.sda_line};
            if (scl_sync_ff[1] == scl_sync_ff[2]) begin
                scl_ff <= scl_sync_ff[2];
            end
            if (sda_sync_ff[1] == sda_sync_ff[2]) begin
                sda_ff <= sda_sync_ff[2];
            end
        end
    end

    assign scl_rise = (scl_sync_ff[1] == scl_sync_ff[2]) && scl_sync_ff[2] && !scl_ff;
    assign scl_fall = (scl_sync_ff[1] == scl_sync_ff[2]) && !scl_sync_ff[2] && scl_ff;
    assign start_det = (sda_sync_ff[1] == sda_sync_ff[2]) && !sda_sync_ff[2] && sda_ff && scl_ff;
    assign stop_det = (sda_sync_ff[1] == sda_sync_ff[2]) && sda_sync_ff[2] && !sda_ff && scl_ff;

    // ***********************************
    // registers
    // ***********************************
    logic [7:0] own_addr_ff;
    logic flag_ff;
    logic ack_en_ff;
    logic start_req_ff;
    logic stop_req_ff;
    logic wcol_ff;
    logic en_ff;
    logic irq_en_ff;
    logic [7:0] status_ff;
    logic [7:0] data_ff;
    logic [7:0] code_ff;
    logic [7:0] sda_shift_ff;
    logic set_flag;
    logic [7:0] set_code;
    logic capture;
    logic stop_recover;
    logic wr_ctrl;
    logic wr_data;
    logic [7:0] ctrl_rd;

    assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
    assign wr_data = reg_wr && (reg_addr == REG_DATA);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            own_addr_ff <= OWN_ADDR_RST;
        end else if (reg_wr && (reg_addr == REG_OWN_ADDR)) begin
            own_addr_ff <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flag_ff <= 1'b0;
            ack_en_ff <= 1'b0;
            start_req_ff <= 1'b0;
            stop_req_ff <= 1'b0;
            en_ff <= 1'b0;
            irq_en_ff <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ack_en_ff <= reg_wdata[CTRL_ACK_EN];
                start_req_ff <= reg_wdata[CTRL_START_REQ];
                stop_req_ff <= reg_wdata[CTRL_STOP_REQ];
                en_ff <= reg_wdata[CTRL_IFACE_EN];
                irq_en_ff <= reg_wdata[CTRL_IRQ_EN];
            end else if (stop_recover) begin
                stop_req_ff <= 1'b0;
            end
            // RQ5: hardware set beats a software clear
            if (set_flag) begin
                flag_ff <= 1'b1;
            end else if (wr_ctrl && reg_wdata[CTRL_IRQ_FLAG]) begin
                flag_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wcol_ff <= 1'b0;
        end else if (wr_data) begin
            wcol_ff <= !flag_ff;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status_ff <= ST_NO_INFO;
        end else if (set_flag) begin
            status_ff <= set_code;
        end else if (wr_ctrl && reg_wdata[CTRL_IRQ_FLAG]) begin
            status_ff <= ST_NO_INFO;
        end
    end

    // RQ10: received byte lands in the data register
    // RQ18: no capture while the clock system sleeps
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data_ff <= DATA_RST;
        end else if (capture && !sleep_mode) begin
            data_ff <= sda_shift_ff;
        end else if (wr_data && flag_ff) begin
            data_ff <= reg_wdata;
        end
    end

    assign ctrl_rd = {flag_ff, ack_en_ff, start_req_ff, stop_req_ff, wcol_ff, en_ff, 1'b0,
                      irq_en_ff};

    // RQ19: prescaler bits read as zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_OWN_ADDR: reg_rdata <= own_addr_ff;
                REG_CTRL: reg_rdata <= ctrl_rd;
                REG_STATUS: reg_rdata <= {status_ff[7:3], 3'h0};
                default: reg_rdata <= data_ff;
            endcase
        end
    end

    // ***********************************
    // link state machine
    // ***********************************
    tws_state_t state_ff;
    logic [3:0] bitcnt_ff;
    logic ack_drive_ff;
    logic gc_mode_ff;
    logic last_nack_ff;
    logic match_own;
    logic match_gc;
    logic addressed;

    // RQ1: own address or enabled general call
    assign match_own = sda_shift_ff[7:1] == own_addr_ff[7:1];
    assign match_gc = (sda_shift_ff[7:1] == GENERAL_CALL_ADDR) && own_addr_ff[0];
    // RQ4: direction bit zero selects receive
    // RQ15: recognition only while ack enable is set
    // RQ16: recognition does not depend on sleep
    assign addressed = !sda_shift_ff[0] && ack_en_ff && (match_own || match_gc);
    assign capture = (state_ff == S_DATA) && scl_fall && (bitcnt_ff == 4'd8);
    assign stop_recover = (state_ff == S_HOLD) && !flag_ff && stop_req_ff;

    always_comb begin
        set_flag = 1'b0;
        set_code = code_ff;
        if ((state_ff == S_ACK) && scl_fall) begin
            set_flag = 1'b1;
        end else if ((state_ff == S_DATA) && (start_det || stop_det)) begin
            // RQ21: stop or restart while addressed
            set_flag = 1'b1;
            set_code = ST_STOP_RESTART;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= S_IDLE;
            bitcnt_ff <= 4'h0;
            sda_shift_ff <= 8'h00;
            ack_drive_ff <= 1'b0;
            gc_mode_ff <= 1'b0;
            last_nack_ff <= 1'b0;
            code_ff <= ST_NO_INFO;
        end else if (!en_ff) begin
            state_ff <= S_IDLE;
            ack_drive_ff <= 1'b0;
        end else begin
            case (state_ff)
                S_IDLE, S_SKIP: begin
                    if (start_det) begin
                        state_ff <= S_ADDR;
                        bitcnt_ff <= 4'h0;
                    end else if (stop_det) begin
                        state_ff <= S_IDLE;
                    end
                end
                S_ADDR, S_DATA: begin
                    if (start_det) begin
                        state_ff <= S_ADDR;
                        bitcnt_ff <= 4'h0;
                    end else if (stop_det) begin
                        state_ff <= S_IDLE;
                    end else if (scl_rise && (bitcnt_ff != 4'd8)) begin
                        sda_shift_ff <= {sda_shift_ff[6:0], sda_ff};
                        bitcnt_ff <= bitcnt_ff + 4'd1;
                    end else if (scl_fall && (bitcnt_ff == 4'd8)) begin
                        if (state_ff == S_DATA) begin
                            // RQ11: ack follows ack enable
                            // RQ14: cleared ack enable gives nack
                            ack_drive_ff <= ack_en_ff;
                            last_nack_ff <= !ack_en_ff;
                            state_ff <= S_ACK;
                            // RQ10: own data acked
                            // RQ12: own data not acked
                            // RQ20: general call data acked
                            if (gc_mode_ff) begin
                                code_ff <= ack_en_ff ? ST_GC_DATA_ACK : ST_GC_DATA_NACK;
                            end else begin
                                code_ff <= ack_en_ff ? ST_DATA_ACK : ST_DATA_NACK;
                            end
                        end else if (addressed) begin
                            ack_drive_ff <= 1'b1;
                            last_nack_ff <= 1'b0;
                            gc_mode_ff <= !match_own;
                            state_ff <= S_ACK;
                            // RQ6: own address
                            // RQ7: own address after lost arbitration
                            // RQ8: general call
                            // RQ9: general call after lost arbitration
                            if (match_own) begin
                                code_ff <= arb_lost ? ST_ARB_SLA_W : ST_SLA_W;
                            end else begin
                                code_ff <= arb_lost ? ST_ARB_GCA : ST_GCA;
                            end
                        end else begin
                            state_ff <= S_SKIP;
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        ack_drive_ff <= 1'b0;
                        state_ff <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    if (!flag_ff) begin
                        bitcnt_ff <= 4'h0;
                        // RQ13: after nack, back to not addressed
                        // RQ22: general call nack handled alike
                        if (last_nack_ff || stop_req_ff) begin
                            state_ff <= S_IDLE;
                        end else begin
                            state_ff <= S_DATA;
                        end
                    end
                end
                default: state_ff <= S_IDLE;
            endcase
        end
    end

    // ***********************************
    // pin drive and wake
    // ***********************************
    assign link.dev_scl_o = 1'b0;
    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe = ack_drive_ff;
    // RQ23: stretch while the flag is set in S_HOLD; a flag set with a0 in S_IDLE or S_ADDR does not stretch
    // RQ17: hold scl low through wake-up
    assign link.dev_scl_oe = (state_ff == S_HOLD) && flag_ff;

    // RQ16: address match wakes the part
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= sleep_mode && flag_ff && (state_ff == S_HOLD);
        end
    end
endmodule

/* File: design/tws_master_tx.sv */
// bus master transmitter end, ordered over apb
`timescale 1ns/1ps
module tws_master_tx (
    // system
    input wire logic clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // two-wire link
    tws_if.master link
);
    import tws_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} tws_host_state_t;

    // ***********************************
    // synchronisers and divider
    // ***********************************
    logic [2:0] scl_sync_ff;
    logic [2:0] sda_sync_ff;
    logic scl_ff;
    logic sda_ff;
    logic [7:0] div_ff;
    logic tick;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_sync_ff <= 3'h7;
            sda_sync_ff <= 3'h7;
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[1:0], link.scl_line};
            sda_sync_ff <= {sda_sync_ff[1:0], link.sda_line};
            if (scl_sync_ff[1] == scl_sync_ff[2]) begin
                scl_ff <= scl_sync_ff[2];
            end
            if (sda_sync_ff[1] == sda_sync_ff[2]) begin
                sda_ff <= sda_sync_ff[2];
            end
        end
    end

    assign tick = div_ff == 8'(SCL_QTR_CYC - 1);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_ff <= 8'h00;
        end else if (tick) begin
            div_ff <= 8'h00;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end

    // ***********************************
    // apb registers
    // ***********************************
    tws_host_state_t state_ff;
    logic [7:0] byte_ff;
    logic do_start_ff;
    logic do_stop_ff;
    logic nack_ff;
    logic go;

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign go = psel && penable && pwrite && (paddr == HOST_CMD_OFS) && (state_ff == H_IDLE);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= 32'h0000_0000;
            if (paddr == HOST_STATUS_OFS) begin
                prdata[STAT_BUSY_BIT] <= state_ff != H_IDLE;
                prdata[STAT_NACK_BIT] <= nack_ff;
            end else if (paddr == HOST_CMD_OFS) begin
                prdata[7:0] <= byte_ff;
            end
        end
    end

    // ***********************************
    // bit engine
    // ***********************************
    logic [1:0] phase_ff;
    logic [3:0] bitcnt_ff;
    logic scl_oe_ff;
    logic sda_oe_ff;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= H_IDLE;
            phase_ff <= 2'h0;
            bitcnt_ff <= 4'h0;
            byte_ff <= 8'h00;
            do_start_ff <= 1'b0;
            do_stop_ff <= 1'b0;
            nack_ff <= 1'b0;
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else if (go) begin
            byte_ff <= pwdata[7:0];
            do_start_ff <= pwdata[CMD_START_BIT];
            do_stop_ff <= pwdata[CMD_STOP_BIT];
            phase_ff <= 2'h0;
            bitcnt_ff <= 4'h0;
            state_ff <= pwdata[CMD_START_BIT] ? H_START : H_BIT;
        end else if (tick && !((phase_ff == 2'h2) && !scl_ff)) begin
            // phase 2 waits while the slave stretches scl
            phase_ff <= phase_ff + 2'h1;
            case (state_ff)
                H_START: begin
                    case (phase_ff)
                        2'h0: sda_oe_ff <= 1'b0;
                        2'h1: scl_oe_ff <= 1'b0;
                        2'h2: sda_oe_ff <= 1'b1;
                        default: begin
                            scl_oe_ff <= 1'b1;
                            state_ff <= H_BIT;
                        end
                    endcase
                end
                H_BIT: begin
                    case (phase_ff)
                        2'h0: sda_oe_ff <= (bitcnt_ff != 4'd8) && !byte_ff[3'(4'd7 - bitcnt_ff)];
                        2'h1: scl_oe_ff <= 1'b0;
                        2'h2: begin
                            if (bitcnt_ff == 4'd8) begin
                                nack_ff <= sda_ff;
                            end
                        end
                        default: begin
                            scl_oe_ff <= 1'b1;
                            bitcnt_ff <= bitcnt_ff + 4'd1;
                            if (bitcnt_ff == 4'd8) begin
                                state_ff <= do_stop_ff ? H_STOP : H_IDLE;
                            end
                        end
                    endcase
                end
                H_STOP: begin
                    case (phase_ff)
                        2'h0: sda_oe_ff <= 1'b1;
                        2'h1: scl_oe_ff <= 1'b0;
                        2'h2: sda_oe_ff <= 1'b1;
                        default: begin
                            sda_oe_ff <= 1'b0;
                            state_ff <= H_IDLE;
                        end
                    endcase
                end
                default: phase_ff <= 2'h0;
            endcase
        end
    end

    assign link.mst_scl_o = 1'b0;
    assign link.mst_sda_o = 1'b0;
    assign link.mst_scl_oe = scl_oe_ff;
    assign link.mst_sda_oe = sda_oe_ff;
endmodule

/* File: test/tws_link_monitor.sv */
// concurrent checks on the two-wire link between both ends
`timescale 1ns/1ps
module tws_link_monitor (
    // system
    input wire logic clk,
    input wire logic nrst,
    // link
    input wire logic dev_scl_oe,
    input wire logic dev_sda_oe,
    input wire logic scl_line
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_ack_hold;
        dev_sda_oe [*8];
    endsequence
    sequence s_stretch;
        ##1 dev_scl_oe;
    endsequence
    a_ack_scl_low: assert property ($rose(dev_sda_oe) |-> !scl_line)
        else $error("ack driven while clock high");
    a_ack_rel_low: assert property ($fell(dev_sda_oe) |-> !scl_line)
        else $error("ack released while clock high");
    a_sda_steady: assert property (scl_line && $past(scl_line) |-> $stable(dev_sda_oe))
        else $error("data moved while clock high");
    a_ack_hold: assert property ($rose(dev_sda_oe) |-> s_ack_hold)
        else $error("ack too short");
    a_ack_bound: assert property ($rose(dev_sda_oe) |-> ##[1:1000] !dev_sda_oe)
        else $error("ack never released");
    a_ack_stretch: assert property ($fell(dev_sda_oe) |-> s_stretch)
        else $error("no stretch after ack");
    a_stretch_low: assert property ($rose(dev_scl_oe) |-> !scl_line)
        else $error("stretch began while clock high");
    a_stretch_quiet: assert property (dev_scl_oe |-> !dev_sda_oe)
        else $error("data held during stretch");
endmodule

/* File: test/test_two_wire_slave_receiver.sv */
// self-checking bench for the two-wire slave receiver link
`timescale 1ns/1ps
module test_two_wire_slave_receiver;
    import tws_pkg::*;
    logic clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, sleep_mode = 0, arb_lost = 0;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, wake_req;
    logic [1:0] reg_addr = 0;
    logic [6:0] adr;
    logic [7:0] reg_wdata = 0, reg_rdata, rd;
    logic [8:0] sh;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    int bad_count = 0, n_tests = 0, cyc = 0;
    tws_if link_if();
    tws_slave_rx tws_slave_rx_inst (.clk(clk), .nrst(nrst), .link(link_if.device),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .sleep_mode(sleep_mode), .arb_lost(arb_lost),
        .wake_req(wake_req));
    tws_master_tx tws_master_tx_inst (.clk(clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_if.master));
    tws_link_monitor tws_link_monitor_inst (.clk(clk), .nrst(nrst),
        .dev_scl_oe(link_if.dev_scl_oe), .dev_sda_oe(link_if.dev_sda_oe),
        .scl_line(link_if.scl_line));
    always #(CLK_PERIOD_NS / 2) clk = ~clk;
    // wire shifter: last byte plus its ack bit
    always @(posedge link_if.scl_line) sh <= {sh[7:0], link_if.sda_line};
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            bad_count++;
            end_sim();
        end
    end
    task end_sim;
        $display("tests %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [8:0] s, input logic [8:0] e);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %0t seen %h want %h", $time, s, e);
        end
    endtask
    task dw(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    task dr(input logic [1:0] a);
        @(posedge clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 rd = reg_rdata;
    endtask
    task ap(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata[7:0];
        chk(pslverr, 1'h0);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // not addressed, or a data byte refused, leaves the ack slot high
    function automatic logic exp_nack(input logic [7:0] code);
        return (code == ST_NO_INFO) || (code == ST_DATA_NACK) || (code == ST_GC_DATA_NACK);
    endfunction
    task wflag;
        do dr(REG_CTRL); while (rd[CTRL_IRQ_FLAG] !== 1'h1);
    endtask
    task xfer(input logic [7:0] b, input logic st, input logic sp,
              input logic [7:0] e1, input logic [7:0] c, input logic [7:0] e2);
        ap(1'h1, HOST_CMD_OFS, {22'h0, sp, st, b});
        if (e1 != ST_NO_INFO) begin
            wflag();
            chk(sh, {b, exp_nack(e1)});
            dr(REG_STATUS);
            chk(rd, e1);
            chk(wake_req, sleep_mode);
            if (e1 == ST_DATA_ACK || e1 == ST_GC_DATA_ACK) begin
                dr(REG_DATA);
                chk(rd, b);
            end
            dw(REG_CTRL, c);
        end
        do ap(1'h0, HOST_STATUS_OFS, 32'h0); while (rd[STAT_BUSY_BIT] !== 1'h0);
        chk(rd[STAT_NACK_BIT], exp_nack(e1));
        if (e2 != ST_NO_INFO) begin
            wflag();
            dr(REG_STATUS);
            chk(rd, e2);
            dw(REG_CTRL, c);
        end
        dr(REG_STATUS);
        chk(rd, ST_NO_INFO);
    endtask
    initial begin
        void'($urandom(8));
        adr = 7'($urandom_range(127, 1));
        repeat (6) @(posedge clk);
        nrst <= 1'h1;
        dr(REG_OWN_ADDR);
        chk(rd, OWN_ADDR_RST);
        dr(REG_STATUS);
        chk(rd, ST_NO_INFO);
        dr(REG_DATA);
        chk(rd, DATA_RST);
        ap(1'h0, 12'h008, 32'h0);
        chk(rd, 8'h00);
        dw(REG_CTRL, 8'h44);
        dw(REG_DATA, 8'h5a);
        dr(REG_CTRL);
        chk(rd, 8'h4c);
        dw(REG_OWN_ADDR, {adr, 1'h0});
        for (int k = 0; k < 4; k++) begin
            if (k == 3)
                dw(REG_CTRL, 8'h04);
            xfer(k == 0 ? {adr ^ 7'h01, 1'h0} : k == 1 ? {adr, 1'h1} : k == 2 ? 8'h00 :
                 {adr, 1'h0}, 1'h1, 1'h1, ST_NO_INFO, 8'h00, ST_NO_INFO);
        end
        dw(REG_OWN_ADDR, {adr, 1'h1});
        dw(REG_CTRL, 8'h44);
        for (int k = 0; k < 4; k++) begin
            arb_lost <= k[0];
            xfer(k[1] ? 8'h00 : {adr, 1'h0}, 1'h1, 1'h0, ST_SLA_W + 8'(k * 8),
                 k[0] ? 8'h84 : 8'hc4, ST_NO_INFO);
            arb_lost <= 1'h0;
            xfer(8'($urandom), 1'h0, 1'h1, ST_DATA_ACK + 8'(k[1] * 16 + k[0] * 8), 8'hc4,
                 k[0] ? ST_NO_INFO : ST_STOP_RESTART);
        end
        sleep_mode <= 1'h1;
        xfer({adr, 1'h0}, 1'h1, 1'h1, ST_SLA_W, 8'hc4, ST_STOP_RESTART);
        sleep_mode <= 1'h0;
        end_sim();
    end
endmodule
